/* File: src/lane_cfg_defs.svh */
/*
 Offsets, reset values, field positions and codes of the lane conditioning
 configuration registers. Assumes it is included by bare name from the register bank
 module and from the bench.
*/
`ifndef LANE_CFG_DEFS_SVH
`define LANE_CFG_DEFS_SVH

`define OFS_L6_DEEMPH      8'h3C
`define OFS_L6_IDLE_THR    8'h3D
`define OFS_L7_IDLE_RATE   8'h40
`define OFS_L7_RX_BOOST    8'h41
`define OFS_L7_SWING       8'h42

`define RST_L6_DEEMPH      8'h03
`define RST_L6_IDLE_THR    8'h00
`define RST_L7_IDLE_RATE   8'h00
`define RST_L7_RX_BOOST    8'h20
`define RST_L7_SWING       8'h03

`define RDATA_NONE         8'h00

`define DEEMPH_TYPE_BIT    7
`define DEEMPH_LVL_MSB     6
`define DEEMPH_LVL_LSB     0
`define DEEMPH_0DB         8'h01
`define DEEMPH_3P5DB       8'h38
`define DEEMPH_6DB         8'h88
`define DEEMPH_9DB         8'h90
`define DEEMPH_12DB        8'hA0
`define DEEMPH_RESERVED    8'hC0

`define THR_DEASSERT_MSB   3
`define THR_DEASSERT_LSB   2
`define THR_ASSERT_MSB     1
`define THR_ASSERT_LSB     0

`define IDLE_AUTO_BIT      5
`define IDLE_SEL_BIT       4
`define RATE_AUTO_BIT      1
`define RATE_SEL_BIT       0

`define EQ_FIELD_MSB       5
`define EQ_EN_BIT          5
`define EQ_GST_MSB         4
`define EQ_GST_LSB         3
`define EQ_BST_MSB         2
`define EQ_BST_LSB         0
`define EQ_BYPASS          6'h20
`define EQ_PRE_0           6'h2A
`define EQ_PRE_1           6'h30
`define EQ_PRE_2           6'h31
`define EQ_PRE_3           6'h38
`define EQ_PRE_4           6'h34
`define EQ_PRE_5           6'h35
`define EQ_PRE_6           6'h3A
`define EQ_PRE_7           6'h3C

`define SWING_MSB          5
`define SWING_WR_MASK      8'h3F
`define SWING_600MV        6'h03
`define SWING_800MV        6'h07
`define SWING_1000MV       6'h0F
`define SWING_1200MV       6'h1F
`define SWING_1400MV       6'h3F

`endif

/* File: src/lane_cfg_pkg.sv */
/*
 Types shared by the lane conditioning register bank. Assumes the defs header
 is on the include path.
*/
package lane_cfg_pkg;

	// One-hot de-emphasis strength classes decoded from the whole byte.
	typedef enum logic [5:0]
	{
		DS_0DB    = 6'h01,
		DS_3P5DB  = 6'h02,
		DS_6DB    = 6'h04,
		DS_9DB    = 6'h08,
		DS_12DB   = 6'h10,
		DS_UNDEF  = 6'h20
	} deemph_strength_t;

endpackage

/* File: src/lane_cfg_regs.sv */
/*
 Configuration register bank for lane 6 de-emphasis and idle threshold and for
 lane 7 idle/rate select, receive boost and output swing, with decoded controls.
 Assumes the management bus front end presents one-cycle read and write strobes
 with an 8-bit register address, all synchronous to i_mclk.
*/
`timescale 1ns/1ps
`include "lane_cfg_defs.svh"

module lane_cfg_regs
(
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	output logic             o_rack,
	output logic             o_l6_deemph_enhanced,
	output logic      [6:0]  o_l6_deemphasis_level,
	output logic      [5:0]  o_l6_deemph_strength,
	output logic      [1:0]  o_l6_idle_deassert_thr,
	output logic      [1:0]  o_l6_idle_assert_thr,
	output logic             o_l7_idle_auto,
	output logic             o_l7_output_mute,
	output logic             o_l7_signal_detect_en,
	output logic             o_l7_rate_auto,
	output logic             o_l7_rate_high,
	output logic             o_l7_receive_boost_en,
	output logic      [1:0]  o_l7_gain_stage,
	output logic      [2:0]  o_l7_boost_level,
	output logic             o_l7_eq_bypass,
	output logic             o_l7_eq_preset,
	output logic      [5:0]  o_l7_output_swing,
	output logic             o_l7_swing_valid
);

	logic [7:0] l6_deemph;
	logic [7:0] l6_idle_thr;
	logic [7:0] l7_idle_rate;
	logic [7:0] l7_rx_boost;
	logic [7:0] l7_swing;
	logic [7:0] next_l6_deemph;
	logic [7:0] next_l6_idle_thr;
	logic [7:0] next_l7_idle_rate;
	logic [7:0] next_l7_rx_boost;
	logic [7:0] next_l7_swing;
	logic [7:0] next_rdata;
	logic       next_rack;
	logic [5:0] next_strength;
	logic       next_mute;
	logic       next_rate_high;
	logic       next_preset;
	logic       next_swing_valid;

	function automatic logic [5:0] deemph_decode(input logic [7:0] code);
		logic [5:0] s;
		s = lane_cfg_pkg::DS_UNDEF;
		unique case (code)
			`DEEMPH_0DB:   s = lane_cfg_pkg::DS_0DB;
			`DEEMPH_3P5DB: s = lane_cfg_pkg::DS_3P5DB;
			`DEEMPH_6DB:   s = lane_cfg_pkg::DS_6DB;
			`DEEMPH_9DB:   s = lane_cfg_pkg::DS_9DB;
			`DEEMPH_12DB:  s = lane_cfg_pkg::DS_12DB;
			default:       s = lane_cfg_pkg::DS_UNDEF;
		endcase
		return s;
	endfunction

	function automatic logic eq_is_preset(input logic [5:0] f);
		return (f == `EQ_PRE_0) || (f == `EQ_PRE_1) || (f == `EQ_PRE_2) ||
		       (f == `EQ_PRE_3) || (f == `EQ_PRE_4) || (f == `EQ_PRE_5) ||
		       (f == `EQ_PRE_6) || (f == `EQ_PRE_7);
	endfunction

	function automatic logic swing_is_valid(input logic [5:0] f);
		return (f == `SWING_600MV) || (f == `SWING_800MV) || (f == `SWING_1000MV) ||
		       (f == `SWING_1200MV) || (f == `SWING_1400MV);
	endfunction

	always_comb
	begin
		next_l6_deemph    = l6_deemph;
		next_l6_idle_thr  = l6_idle_thr;
		next_l7_idle_rate = l7_idle_rate;
		next_l7_rx_boost  = l7_rx_boost;
		next_l7_swing     = l7_swing;
		if (i_wr)
		begin
			// Each offset loads its own register only.
			unique case (i_addr)
				`OFS_L6_DEEMPH:    next_l6_deemph    = i_wdata;
				`OFS_L6_IDLE_THR:  next_l6_idle_thr  = i_wdata;
				`OFS_L7_IDLE_RATE: next_l7_idle_rate = i_wdata;
				`OFS_L7_RX_BOOST:  next_l7_rx_boost  = i_wdata;
				// Bits 7:6 of the swing register are read-only zero.
				`OFS_L7_SWING:     next_l7_swing     = i_wdata & `SWING_WR_MASK;
				default:           next_l6_deemph    = l6_deemph;
			endcase
		end
		next_rack  = i_rd;
		next_rdata = `RDATA_NONE;
		if (i_rd)
		begin
			unique case (i_addr)
				`OFS_L6_DEEMPH:    next_rdata = l6_deemph;
				`OFS_L6_IDLE_THR:  next_rdata = l6_idle_thr;
				`OFS_L7_IDLE_RATE: next_rdata = l7_idle_rate;
				`OFS_L7_RX_BOOST:  next_rdata = l7_rx_boost;
				`OFS_L7_SWING:     next_rdata = l7_swing;
				default:           next_rdata = `RDATA_NONE;
			endcase
		end
		next_strength = deemph_decode(next_l6_deemph);
		// Automatic idle detection overrides the manual select.
		next_mute = ~next_l7_idle_rate[`IDLE_AUTO_BIT] &
		            next_l7_idle_rate[`IDLE_SEL_BIT];
		next_rate_high = ~next_l7_idle_rate[`RATE_AUTO_BIT] &
		                 next_l7_idle_rate[`RATE_SEL_BIT];
		next_preset      = eq_is_preset(next_l7_rx_boost[`EQ_FIELD_MSB:0]);
		next_swing_valid = swing_is_valid(next_l7_swing[`SWING_MSB:0]);
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			l6_deemph              <= `RST_L6_DEEMPH;
			l6_idle_thr            <= `RST_L6_IDLE_THR;
			l7_idle_rate           <= `RST_L7_IDLE_RATE;
			l7_rx_boost            <= `RST_L7_RX_BOOST;
			l7_swing               <= `RST_L7_SWING;
			o_rdata                <= `RDATA_NONE;
			o_rack                 <= 1'b0;
			o_l6_deemph_enhanced   <= 1'(`RST_L6_DEEMPH >> `DEEMPH_TYPE_BIT);
			o_l6_deemphasis_level  <= 7'(`RST_L6_DEEMPH);
			o_l6_deemph_strength   <= lane_cfg_pkg::DS_UNDEF;
			o_l6_idle_deassert_thr <= 2'h0;
			o_l6_idle_assert_thr   <= 2'h0;
			o_l7_idle_auto         <= 1'b0;
			o_l7_output_mute       <= 1'b0;
			o_l7_signal_detect_en  <= 1'b0;
			o_l7_rate_auto         <= 1'b0;
			o_l7_rate_high         <= 1'b0;
			o_l7_receive_boost_en  <= 1'(`RST_L7_RX_BOOST >> `EQ_EN_BIT);
			o_l7_gain_stage        <= 2'h0;
			o_l7_boost_level       <= 3'h0;
			o_l7_eq_bypass         <= 1'b1;
			o_l7_eq_preset         <= 1'b0;
			o_l7_output_swing      <= `SWING_600MV;
			o_l7_swing_valid       <= 1'b1;
		end
		else
		begin
			l6_deemph              <= next_l6_deemph;
			l6_idle_thr            <= next_l6_idle_thr;
			l7_idle_rate           <= next_l7_idle_rate;
			l7_rx_boost            <= next_l7_rx_boost;
			l7_swing               <= next_l7_swing;
			o_rdata                <= next_rdata;
			o_rack                 <= next_rack;
			o_l6_deemph_enhanced   <= next_l6_deemph[`DEEMPH_TYPE_BIT];
			o_l6_deemphasis_level  <= next_l6_deemph[`DEEMPH_LVL_MSB:`DEEMPH_LVL_LSB];
			o_l6_deemph_strength   <= next_strength;
			o_l6_idle_deassert_thr <= next_l6_idle_thr[`THR_DEASSERT_MSB:`THR_DEASSERT_LSB];
			o_l6_idle_assert_thr   <= next_l6_idle_thr[`THR_ASSERT_MSB:`THR_ASSERT_LSB];
			o_l7_idle_auto         <= next_l7_idle_rate[`IDLE_AUTO_BIT];
			o_l7_output_mute       <= next_mute;
			// Signal detect runs only under automatic idle control.
			o_l7_signal_detect_en  <= next_l7_idle_rate[`IDLE_AUTO_BIT];
			o_l7_rate_auto         <= next_l7_idle_rate[`RATE_AUTO_BIT];
			o_l7_rate_high         <= next_rate_high;
			o_l7_receive_boost_en  <= next_l7_rx_boost[`EQ_EN_BIT];
			o_l7_gain_stage        <= next_l7_rx_boost[`EQ_GST_MSB:`EQ_GST_LSB];
			o_l7_boost_level       <= next_l7_rx_boost[`EQ_BST_MSB:`EQ_BST_LSB];
			o_l7_eq_bypass         <= (next_l7_rx_boost[`EQ_FIELD_MSB:0] == `EQ_BYPASS);
			o_l7_eq_preset         <= next_preset;
			o_l7_output_swing      <= next_l7_swing[`SWING_MSB:0];
			o_l7_swing_valid       <= next_swing_valid;
		end
	end

	sequence s_write(logic [7:0] a);
		i_wr && (i_addr == a);
	endsequence

	sequence s_no_write(logic [7:0] a);
		!(i_wr && (i_addr == a));
	endsequence

	a_deemph_type_bit: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		s_write(`OFS_L6_DEEMPH) |=> o_l6_deemph_enhanced == $past(i_wdata[`DEEMPH_TYPE_BIT]))
		else $error("De-emphasis type does not follow the written bit 7.");

	a_deemph_level_code: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		s_write(`OFS_L6_DEEMPH) |=> o_l6_deemphasis_level == $past(i_wdata[6:0]))
		else $error("De-emphasis level does not follow the written bits 6 to 0.");

	a_deemph_strength_map: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L6_DEEMPH) ##0 (i_wdata == `DEEMPH_6DB)) |=>
		(o_l6_deemph_strength == lane_cfg_pkg::DS_6DB) ##1
		((o_l6_deemph_strength == lane_cfg_pkg::DS_6DB) ||
		$past(i_wr && (i_addr == `OFS_L6_DEEMPH))))
		else $error("De-emphasis byte 88h did not decode to -6 dB.");

	a_idle_thr_fields: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		s_write(`OFS_L6_IDLE_THR) |=>
		{o_l6_idle_deassert_thr, o_l6_idle_assert_thr} == $past(i_wdata[3:0]))
		else $error("Idle threshold fields do not follow the written bits 3 to 0.");

	a_manual_idle_mute: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		o_l7_output_mute |-> !o_l7_idle_auto && !o_l7_signal_detect_en &&
		l7_idle_rate[`IDLE_SEL_BIT])
		else $error("Output muted without manual idle select set.");

	a_auto_idle_detect: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_IDLE_RATE) ##0 i_wdata[`IDLE_AUTO_BIT]) |=>
		o_l7_signal_detect_en && !o_l7_output_mute)
		else $error("Automatic idle detect did not take over muting.");

	a_manual_rate_pick: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_IDLE_RATE) ##0 !i_wdata[`RATE_AUTO_BIT]) |=>
		o_l7_rate_high == $past(i_wdata[`RATE_SEL_BIT]) && !o_l7_rate_auto)
		else $error("Manual rate select not applied.");

	a_auto_rate_ovr: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		o_l7_rate_auto |-> !o_l7_rate_high)
		else $error("Manual rate select active under automatic rate detect.");

	a_eq_fields: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		s_write(`OFS_L7_RX_BOOST) |=>
		{o_l7_receive_boost_en, o_l7_gain_stage, o_l7_boost_level} == $past(i_wdata[5:0]))
		else $error("Equalizer fields do not follow the written bits 5 to 0.");

	a_eq_bypass_hold: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		o_l7_eq_bypass |-> o_l7_receive_boost_en && o_l7_gain_stage == 2'h0 &&
		o_l7_boost_level == 3'h0)
		else $error("Bypass flagged for a non-bypass equalizer value.");

	a_eq_preset_hit: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_RX_BOOST) ##0 (i_wdata == {2'h0, `EQ_PRE_7})) |=> o_l7_eq_preset)
		else $error("Equalizer value 3Ch not recognised as a preset.");

	a_swing_write: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		s_write(`OFS_L7_SWING) |=> o_l7_output_swing == $past(i_wdata[5:0]) &&
		l7_swing[7:6] == 2'h0)
		else $error("Swing field not applied or reserved bits not zero.");

	a_lane_isolation: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		s_no_write(`OFS_L6_DEEMPH) ##0 s_no_write(`OFS_L6_IDLE_THR) |=>
		$stable(o_l6_deemphasis_level) && $stable(o_l6_idle_assert_thr))
		else $error("Lane 6 controls changed without a lane 6 write.");

	a_deemph_zero_db: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L6_DEEMPH) ##0 (i_wdata == `DEEMPH_0DB)) |=>
		o_l6_deemph_strength == lane_cfg_pkg::DS_0DB)
		else $error("De-emphasis byte 01h did not decode to 0 dB.");

	a_idle_manual_on: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_IDLE_RATE) ##0 (!i_wdata[`IDLE_AUTO_BIT] && !i_wdata[`IDLE_SEL_BIT])) |=>
		!o_l7_output_mute && !o_l7_signal_detect_en)
		else $error("Manual idle select at zero did not keep the output on.");

	a_idle_manual_mute: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_IDLE_RATE) ##0 (!i_wdata[`IDLE_AUTO_BIT] && i_wdata[`IDLE_SEL_BIT])) |=>
		o_l7_output_mute && !o_l7_signal_detect_en)
		else $error("Manual idle select at one did not mute the output.");

	a_auto_rate_take: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_IDLE_RATE) ##0 i_wdata[`RATE_AUTO_BIT]) |=>
		o_l7_rate_auto && !o_l7_rate_high)
		else $error("Automatic rate detect did not take over the rate select.");

	a_eq_bypass_write: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_RX_BOOST) ##0 (i_wdata == {2'h0, `EQ_BYPASS})) |=>
		o_l7_eq_bypass && !o_l7_eq_preset)
		else $error("Equalizer value 20h not recognised as bypass.");

	a_swing_valid_code: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		(s_write(`OFS_L7_SWING) ##0 (i_wdata == {2'h0, `SWING_1400MV})) |=>
		o_l7_swing_valid && o_l7_output_swing == `SWING_1400MV)
		else $error("Swing code 3Fh not recognised as a valid setting.");

	a_lane7_isolation: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		s_no_write(`OFS_L7_IDLE_RATE) ##0 s_no_write(`OFS_L7_RX_BOOST) ##0
		s_no_write(`OFS_L7_SWING) |=>
		$stable(o_l7_output_swing) && $stable(o_l7_gain_stage) && $stable(o_l7_output_mute))
		else $error("Lane 7 controls changed without a lane 7 write.");

endmodule

/* File: dv/mgmt_host_model.sv */
/*
 Behavioural management host that issues one-cycle write and read strobes to
 the lane conditioning register bank. Assumes the bench calls its tasks and
 that the bank answers a read at the taking edge, ready by the next falling edge.
*/
`timescale 1ns/1ps

module mgmt_host_model
(
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rack,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd
);
	initial
	begin
		o_addr  = 8'h00;
		o_wdata = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end

	function automatic logic [7:0] legal_mask(input logic [7:0] addr);
		case (addr)
			8'h3D:   legal_mask = 8'h0F;
			8'h40:   legal_mask = 8'h33;
			8'h41:   legal_mask = 8'h3F;
			8'h42:   legal_mask = 8'h3F;
			default: legal_mask = 8'hFF;
		endcase
	endfunction

	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] val;
		val = data & legal_mask(addr);
		// The reserved de-emphasis byte C0h is never sent; the write is dropped.
		if (!(addr == 8'h3C && val == 8'hC0))
		begin
			@(posedge i_mclk);
			o_addr  <= addr;
			o_wdata <= val;
			o_wr    <= 1'b1;
			@(posedge i_mclk);
			o_wr    <= 1'b0;
		end
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ack);
		@(posedge i_mclk);
		o_addr <= addr;
		o_rd   <= 1'b1;
		@(posedge i_mclk);
		o_rd   <= 1'b0;
		@(negedge i_mclk);
		data = i_rdata;
		ack  = i_rack;
	endtask
endmodule

/* File: dv/tb_top.sv */
/*
 Self-checking bench for the lane conditioning register bank. Assumes the bank
 and the host model are compiled before it and the defs header is on the path.
*/
`timescale 1ns/1ps
`include "lane_cfg_defs.svh"

module tb_top;
	logic       i_mclk = 1'b0;
	logic       i_resetn = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic       wr, rd, rack, en, mute, sd, ia, ra, rh, ben, byp, pre, sv;
	logic [6:0] lvl;
	logic [5:0] str, swing;
	logic [1:0] dthr, athr, gain_stage;
	logic [2:0] boost_level;
	int         failures = 0;
	int         checks_done = 0;
	int         cycles = 0;
	logic [7:0] dem_b [5] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0};
	logic [5:0] dem_s [5] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10};
	logic [7:0] eq_v [10] = '{8'h20, 8'h2A, 8'h30, 8'h31, 8'h38, 8'h34, 8'h35, 8'h3A, 8'h3C, 8'h21};
	logic [7:0] sw_v [6] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h05};
	logic [7:0] rst_a [5] = '{8'h3C, 8'h3D, 8'h40, 8'h41, 8'h42};
	logic [7:0] rst_v [5] = '{8'h03, 8'h00, 8'h00, 8'h20, 8'h03};
	logic [7:0] v8;

	always #2 i_mclk = ~i_mclk;

	lane_cfg_regs u_lane_cfg_regs
	(
		.i_mclk                 (i_mclk),
		.i_resetn               (i_resetn),
		.i_addr                 (addr),
		.i_wdata                (wdata),
		.i_wr                   (wr),
		.i_rd                   (rd),
		.o_rdata                (rdata),
		.o_rack                 (rack),
		.o_l6_deemph_enhanced   (en),
		.o_l6_deemphasis_level  (lvl),
		.o_l6_deemph_strength   (str),
		.o_l6_idle_deassert_thr (dthr),
		.o_l6_idle_assert_thr   (athr),
		.o_l7_idle_auto         (ia),
		.o_l7_output_mute       (mute),
		.o_l7_signal_detect_en  (sd),
		.o_l7_rate_auto         (ra),
		.o_l7_rate_high         (rh),
		.o_l7_receive_boost_en  (ben),
		.o_l7_gain_stage        (gain_stage),
		.o_l7_boost_level       (boost_level),
		.o_l7_eq_bypass         (byp),
		.o_l7_eq_preset         (pre),
		.o_l7_output_swing      (swing),
		.o_l7_swing_valid       (sv)
	);

	mgmt_host_model u_mgmt_host_model
	(
		.i_mclk  (i_mclk),
		.i_rdata (rdata),
		.i_rack  (rack),
		.o_addr  (addr),
		.o_wdata (wdata),
		.o_wr    (wr),
		.o_rd    (rd)
	);

	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       k;
		u_mgmt_host_model.read_reg(a, d, k);
		chk({7'h00, k}, 8'h01);
		chk(d, exp);
		// The answer stands for one cycle only.
		@(negedge i_mclk);
		chk({7'h00, rack}, 8'h00);
		chk(rdata, 8'h00);
	endtask

	// Writes, then lets the taking edge land before any output is looked at.
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		u_mgmt_host_model.write_reg(a, v);
		@(negedge i_mclk);
	endtask

	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			end_sim();
		end
	end

	initial
	begin
		repeat (16) @(posedge i_mclk);
		i_resetn <= 1'b1;
		@(negedge i_mclk);
		chk({str, byp, sv}, {6'h20, 2'b11});
		for (int i = 0; i < 5; i++)
			rd_chk(rst_a[i], rst_v[i]);
		rd_chk(8'h3E, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			put(`OFS_L6_DEEMPH, dem_b[i]);
			chk({2'b00, str}, {2'b00, dem_s[i]});
			chk({en, lvl}, dem_b[i]);
			rd_chk(`OFS_L6_DEEMPH, dem_b[i]);
		end
		for (int t = 0; t < 16; t++)
		begin
			put(`OFS_L6_IDLE_THR, t[7:0]);
			chk({4'h0, dthr, athr}, t[7:0]);
		end
		for (int v = 0; v < 16; v++)
		begin
			v8 = {2'b00, v[3], v[2], 2'b00, v[1], v[0]};
			put(`OFS_L7_IDLE_RATE, v8);
			chk({3'b000, ia, mute, sd, ra, rh}, {3'b000, v[3], !v[3] & v[2], v[3], v[1], !v[1] & v[0]});
		end
		for (int i = 0; i < 10; i++)
		begin
			put(`OFS_L7_RX_BOOST, eq_v[i]);
			chk({2'b00, ben, gain_stage, boost_level}, eq_v[i]);
			chk({6'h00, byp, pre}, {6'h00, i == 0, i > 0 && i < 9});
		end
		for (int i = 0; i < 6; i++)
		begin
			put(`OFS_L7_SWING, sw_v[i]);
			chk({1'b0, sv, swing}, {1'b0, i < 5, sw_v[i][5:0]});
			rd_chk(`OFS_L7_SWING, sw_v[i]);
		end
		put(8'h3E, 8'h55);
		chk({2'b00, str}, 8'h10);
		chk({4'h0, dthr, athr}, 8'h0F);
		rd_chk(`OFS_L6_DEEMPH, 8'hA0);
		// A second reset in mid-run must bring back every reset value.
		@(posedge i_mclk);
		i_resetn <= 1'b0;
		@(negedge i_mclk);
		chk({byp, sv, swing}, 8'hC3);
		@(posedge i_mclk);
		i_resetn <= 1'b1;
		@(negedge i_mclk);
		chk({2'b00, str}, 8'h20);
		rd_chk(`OFS_L7_RX_BOOST, 8'h20);
		end_sim();
	end
endmodule
